// ==== lss_pkg.sv ====
// Functional notes
// (R1) send takes 16 ticks, wait at least 16
// (R2) engines latch received triggers until consumed
// (R3) matching wait clears the latched triggers
// (R4) wait stalls until all selected triggers seen
// (R5) external trigger needs two ticks low
// (R6) sent external trigger lasts three ticks
// (R7) external trigger line is active low
// (R8) own driven pulse is never received
// (R9) external send completes before external wait
// (R10) wait mask 12:7, send mask 6:1
// (R11) top bits 111 decode as trigger
// (R12) power save only with enable bit set
// (R13) engines keep running during power save
// (R14) all three channels must allow power save
// (R15) mode decides power save eligibility
// (R16) look-ahead checks each channel instruction
// (R17) wait qualifies beyond 50/80 ms idle
// (R18) ramp at zero qualifies beyond 50/80 ms
// (R19) zero set-pwm needs 50 ms following wait
// (R20) pwm demand in power save starts wake-up
// (R21) clock source field selects ext/int/auto
// (R22) detector: stuck or under 15 kHz absent
// (R23) status bit shows detected outside clock
// (R24) auto selection falls back to internal
package lss_pkg;
   localparam int SYS_HZ = 100_000_000;
   localparam int SEQ_HZ = 32768;
   localparam int INT_DIV = SYS_HZ / SEQ_HZ;
   localparam int DET_MIN_HZ = 15000;
   localparam int DET_LIMIT = SYS_HZ / DET_MIN_HZ;
   localparam int CMD_TICKS = 16;
   localparam int RX_MIN_TICKS = 2;
   localparam int TX_TICKS = 3;
   localparam int PS_MS_FAST = 50;
   localparam int PS_MS_SLOW = 80;
   localparam logic [15:0] PS_TICKS_FAST = 16'(PS_MS_FAST * SEQ_HZ / 1000);
   localparam logic [15:0] PS_TICKS_SLOW = 16'(PS_MS_SLOW * SEQ_HZ / 1000);
   localparam logic [7:0] REG_SETUP = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] SETUP_RESET = 8'h00;
   localparam int SETUP_CLK_LSB = 0;
   localparam int SETUP_DET_BIT = 1;
   localparam int SETUP_PS_BIT = 5;
   localparam int STATUS_CLK_BIT = 0;
   localparam logic [1:0] CLK_EXT = 2'h0;
   localparam logic [1:0] CLK_AUTO = 2'h2;
   localparam int TRG_WAIT_LSB = 7;
   localparam int TRG_SEND_LSB = 1;
   localparam int SRC_EXT = 5;
   localparam logic [5:0] SRC_USED = 6'h27;
   localparam int RAMP_PRESCALE_BIT = 14;
   localparam int END_RESET_BIT = 11;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_LOAD = 2'h1;
   localparam logic [1:0] MODE_RUN = 2'h2;
   localparam logic [1:0] MODE_DIRECT = 2'h3;
   typedef enum logic [2:0] {
      CMD_GOSTART = 3'h0, CMD_RAMP = 3'h1, CMD_WAIT = 3'h2, CMD_SETPWM = 3'h3,
      CMD_BRANCH = 3'h4, CMD_END = 3'h5, CMD_TRIG = 3'h6, CMD_OTHER = 3'h7
   } lss_cmd_t;
   typedef enum logic [1:0] {E_IDLE = 2'h0, E_SEND = 2'h1, E_WAIT = 2'h2} lss_eng_t;
   // bit 0 of a trigger word is a don't-care
   function automatic lss_cmd_t lss_decode(input logic [15:0] ins);
      if (ins[15:13] == 3'h7) return CMD_TRIG; // [R11]
      if (ins[15:13] == 3'h6) return CMD_END;
      if (ins[15:13] == 3'h5) return CMD_BRANCH;
      if (ins[15]) return CMD_OTHER;
      if (ins == 16'h0000) return CMD_GOSTART;
      if (ins[15:8] == 8'h40) return CMD_SETPWM;
      if (ins[6:0] == 7'h00) return CMD_WAIT;
      return CMD_RAMP;
   endfunction
endpackage

// ==== lss_trig_rx.sv ====
`timescale 1ns/1ps
module lss_trig_rx
   import lss_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic trig_in,
   input wire logic tick,
   input wire logic self_drive,
   output logic rx_pulse
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic blank;
      logic [1:0] low_cnt;
      logic pulse;
   } lss_rx_t;
   lss_rx_t st, next_st;
   // low must persist over two ticks; own pulse blanks until a tick after release
   always_comb begin
      next_st = st;
      next_st.s1 = trig_in;
      next_st.s2 = st.s1;
      next_st.pulse = 1'b0;
      if (self_drive) begin
         next_st.blank = 1'b1; // [R8]
      end else if (tick) begin
         next_st.blank = 1'b0;
      end
      if (self_drive || st.blank) begin
         next_st.low_cnt = 2'h0;
      end else if (tick) begin
         if (!st.s2) begin // [R7]
            if (st.low_cnt != 2'(RX_MIN_TICKS)) begin
               next_st.low_cnt = st.low_cnt + 2'h1;
            end
            next_st.pulse = (st.low_cnt == 2'(RX_MIN_TICKS - 1)); // [R5]
         end else begin
            next_st.low_cnt = 2'h0;
         end
      end
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '{s1: 1'b1, s2: 1'b1, blank: 1'b0, low_cnt: 2'h0, pulse: 1'b0};
      end else begin
         st <= next_st;
      end
   end
   assign rx_pulse = st.pulse;
   AST_RX_NOT_SELF: assert property (@(posedge sys_clk) disable iff (!reset_n)
      rx_pulse |-> !$past(self_drive) && !$past(st.blank)) // [R8]
      else $error("own trigger pulse was received");
   AST_RX_TWO_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(rx_pulse) |-> $past(st.low_cnt) == 2'h1 && !$past(st.s2)) // [R5]
      else $error("trigger accepted before two low ticks");
endmodule // lss_trig_rx

// ==== lss_clk_det.sv ====
`timescale 1ns/1ps
module lss_clk_det
   import lss_pkg::*;
#(
   parameter int LIMIT = DET_LIMIT
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic slow_clock_input,
   input wire logic enable,
   output logic present,
   output logic edge_pulse
);
   if (LIMIT < 4 || LIMIT > 65535) begin : g_chk
      $error("LIMIT out of range");
   end
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic [15:0] cnt;
      logic present;
   } lss_det_t;
   lss_det_t st, next_st;
   logic rise;
   assign rise = st.s2 && !st.s3;
   // period measured between rising edges; saturating count catches stuck levels
   always_comb begin
      next_st = st;
      next_st.s1 = slow_clock_input;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if (rise) begin
         next_st.cnt = 16'h0000;
         next_st.present = enable && (st.cnt < 16'(LIMIT)); // [R22]
      end else if (st.cnt >= 16'(LIMIT)) begin
         next_st.present = 1'b0; // [R22]
      end else begin
         next_st.cnt = st.cnt + 16'h0001;
      end
      if (!enable) next_st.present = 1'b0;
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign present = st.present;
   assign edge_pulse = rise;
   AST_DET_STUCK: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (st.cnt >= 16'(LIMIT)) && !rise |=> !present) // [R22]
      else $error("stuck outside clock reported present");
endmodule // lss_clk_det

// ==== lss_sequencer_sync.sv ====
`timescale 1ns/1ps
module lss_sequencer_sync
   import lss_pkg::*;
#(
   parameter int DET_CYCLES = DET_LIMIT
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic slow_clock_input,
   input wire logic trig_in,
   output logic trig_out,
   output logic trig_oe,
   input wire logic [2:0] chan_issue,
   input wire logic [47:0] chan_instr,
   output logic [2:0] chan_done,
   input wire logic [5:0] chan_mode,
   input wire logic [2:0] pwm_active,
   input wire logic [47:0] time_left,
   input wire logic [47:0] next_wait,
   output logic seq_tick,
   output logic power_save,
   output logic wake_start,
   output logic outside_clock_present
);
   import lss_pkg::*;
   if (INT_DIV < 2 || INT_DIV > 4095) begin : g_chk
      $error("internal divider out of range");
   end
   typedef struct packed {
      logic [11:0] div;
      logic ext_sel;
      logic tick;
      logic [7:0] setup;
      logic [7:0] rdata;
      lss_eng_t [2:0] eng;
      logic [2:0][3:0] cnt;
      logic [2:0][5:0] wmask;
      logic [2:0][5:0] lat;
      logic [2:0] done;
      logic tx_req;
      logic tx_on;
      logic [1:0] tx_cnt;
      logic ps;
      logic wake;
   } lss_state_t;
   lss_state_t st, next_st;
   logic det_present, det_edge, rx_pulse, ps_all;
   logic [2:0] ps_ok;
   logic [2:0][5:0] setv, clrv;
   logic [1:0] clk_src;
   logic det_en;
   assign clk_src = st.setup[SETUP_CLK_LSB +: 2];
   assign det_en = st.setup[SETUP_DET_BIT];

   lss_clk_det #(.LIMIT(DET_CYCLES)) u_det (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .slow_clock_input(slow_clock_input),
      .enable(det_en),
      .present(det_present),
      .edge_pulse(det_edge)
   );

   lss_trig_rx u_rx (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .trig_in(trig_in),
      .tick(st.tick),
      .self_drive(st.tx_on),
      .rx_pulse(rx_pulse)
   );

   // per-channel look-ahead; evaluated each cycle so it tracks every instruction
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         logic [15:0] ins;
         logic [15:0] tl;
         logic [15:0] thr;
         ins = chan_instr[16*i +: 16];
         tl = time_left[16*i +: 16];
         thr = ins[RAMP_PRESCALE_BIT] ? PS_TICKS_SLOW : PS_TICKS_FAST;
         ps_ok[i] = 1'b0;
         unique case (chan_mode[2*i +: 2]) // [R15]
            MODE_OFF: ps_ok[i] = 1'b1;
            MODE_LOAD: ps_ok[i] = 1'b0;
            MODE_DIRECT: ps_ok[i] = !pwm_active[i];
            MODE_RUN: begin // [R16]
               unique case (lss_decode(ins))
                  CMD_WAIT: ps_ok[i] = !pwm_active[i] && (tl > thr); // [R17]
                  CMD_RAMP: ps_ok[i] = !pwm_active[i] && (tl > thr); // [R18]
                  CMD_SETPWM: ps_ok[i] = (ins[7:0] == 8'h00)
                     && (next_wait[16*i +: 16] >= PS_TICKS_FAST); // [R19]
                  CMD_END: ps_ok[i] = !pwm_active[i] || ins[END_RESET_BIT];
                  CMD_TRIG: ps_ok[i] = !pwm_active[i];
                  default: ps_ok[i] = !pwm_active[i];
               endcase
            end
         endcase
      end
   end
   assign ps_all = st.setup[SETUP_PS_BIT] && (&ps_ok); // [R12] [R14]

   // main next-state: clock select, trigger engines, external pulse, registers
   always_comb begin
      next_st = st;
      setv = '0;
      clrv = '0;
      next_st.done = 3'h0;
      // clock source: forced outside, internal, or detector-steered
      unique case (clk_src)
         CLK_EXT: next_st.ext_sel = 1'b1; // [R21]
         CLK_AUTO: next_st.ext_sel = det_present; // [R23] [R24]
         default: next_st.ext_sel = 1'b0; // [R21]
      endcase
      next_st.div = (st.div == 12'(INT_DIV - 1)) ? 12'h000 : st.div + 12'h001;
      next_st.tick = st.ext_sel ? det_edge : (st.div == 12'(INT_DIV - 1));
      // engines run regardless of power save
      for (int i = 0; i < 3; i++) begin // [R13]
         logic [15:0] ins;
         logic [5:0] snd;
         ins = chan_instr[16*i +: 16];
         snd = ins[TRG_SEND_LSB +: 6] & SRC_USED; // [R10]
         unique case (st.eng[i])
            E_IDLE: begin
               if (chan_issue[i] && lss_decode(ins) == CMD_TRIG) begin // [R11]
                  for (int j = 0; j < 3; j++) begin
                     setv[j][i] = snd[j]; // [R2]
                  end
                  if (snd[SRC_EXT]) next_st.tx_req = 1'b1;
                  next_st.wmask[i] = ins[TRG_WAIT_LSB +: 6] & SRC_USED; // [R10]
                  next_st.cnt[i] = 4'h0;
                  next_st.eng[i] = E_SEND;
               end
            end
            E_SEND: begin
               if (st.tick) begin
                  if (st.cnt[i] == 4'(CMD_TICKS - 1)) begin // [R1]
                     if (st.wmask[i] == 6'h00) begin
                        next_st.done[i] = 1'b1;
                        next_st.eng[i] = E_IDLE;
                     end else begin
                        next_st.eng[i] = E_WAIT;
                     end
                  end else begin
                     next_st.cnt[i] = st.cnt[i] + 4'h1;
                  end
               end
            end
            E_WAIT: begin
               // stall until every selected source latched; ext send must finish first
               if ((st.lat[i] & st.wmask[i]) == st.wmask[i] // [R4]
                   && !(st.wmask[i][SRC_EXT] && (st.tx_req || st.tx_on))) begin // [R9]
                  clrv[i] = st.wmask[i]; // [R3]
                  next_st.done[i] = 1'b1;
                  next_st.eng[i] = E_IDLE;
               end
            end
            default: next_st.eng[i] = E_IDLE;
         endcase
         if (rx_pulse) setv[i][SRC_EXT] = 1'b1; // [R2]
      end
      // set beats clear so a trigger arriving at consume time survives
      for (int i = 0; i < 3; i++) begin
         next_st.lat[i] = (st.lat[i] & ~clrv[i]) | setv[i]; // [R2] [R3]
      end
      // line pulse starts on a tick so it spans exactly three tick periods
      if (st.tick) begin
         if (st.tx_on) begin
            if (st.tx_cnt == 2'(TX_TICKS - 1)) begin // [R6]
               next_st.tx_on = 1'b0;
            end else begin
               next_st.tx_cnt = st.tx_cnt + 2'h1;
            end
         end else if (st.tx_req) begin
            next_st.tx_req = 1'b0;
            next_st.tx_on = 1'b1;
            next_st.tx_cnt = 2'h0;
         end
      end
      // power save and wake-up when pwm is needed again
      next_st.ps = ps_all;
      next_st.wake = st.ps && !ps_all && (|pwm_active); // [R20]
      // register port: writes to the setup word, registered read data
      if (reg_wr && reg_addr == REG_SETUP) next_st.setup = reg_wdata;
      unique case (reg_addr)
         REG_SETUP: next_st.rdata = st.setup;
         REG_STATUS: begin
            next_st.rdata = 8'h00;
            next_st.rdata[STATUS_CLK_BIT] = det_en && det_present; // [R23]
         end
         default: next_st.rdata = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
         st.setup <= SETUP_RESET;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from flops, except outside_clock_present (det_present gated by det_en) and trig_out, tied low; line is open drain, driven only low
   assign reg_rdata = st.rdata;
   assign trig_out = 1'b0; // [R7]
   assign trig_oe = st.tx_on; // [R6]
   assign chan_done = st.done;
   assign seq_tick = st.tick;
   assign power_save = st.ps;
   assign wake_start = st.wake;
   assign outside_clock_present = det_en && det_present;

   // helper: ticks counted while the line is pulled
   logic [2:0] tx_ticks;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) tx_ticks <= 3'h0;
      else if (!st.tx_on) tx_ticks <= 3'h0;
      else if (st.tick) tx_ticks <= tx_ticks + 3'h1;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   AST_PS_NEEDS_EN: assert property (power_save |-> $past(st.setup[SETUP_PS_BIT])) // [R12]
      else $error("power save without enable");
   AST_PS_LOAD_BLOCKS: assert property (
      $past(chan_mode[1:0]) == MODE_LOAD |-> !power_save) // [R15]
      else $error("load mode did not block power save");
   AST_PS_ALL: assert property (power_save |-> &$past(ps_ok)) // [R14]
      else $error("power save with a channel not eligible");
   // helper steps to three on the very edge that drops the pulse, so look at it now
   AST_TX_THREE: assert property ($fell(trig_oe) |-> tx_ticks == 3'h3) // [R6]
      else $error("trigger pulse not three ticks");
   AST_SEND_16: assert property (
      chan_done[0] && $past(st.eng[0]) == E_SEND |-> $past(st.cnt[0]) == 4'hF) // [R1]
      else $error("send instruction not sixteen ticks");
   AST_WAIT_MATCH: assert property (
      chan_done[1] && $past(st.eng[1]) == E_WAIT
      |-> ($past(st.lat[1]) & $past(st.wmask[1])) == $past(st.wmask[1])) // [R4]
      else $error("wait ended before triggers");
   AST_LAT_HOLD: assert property (
      $fell(st.lat[1][0]) |-> $past(st.eng[1]) == E_WAIT && chan_done[1]) // [R2]
      else $error("latched trigger lost");
   AST_EXT_ORDER: assert property (
      chan_done[0] && $past(st.wmask[0][SRC_EXT]) && $past(st.eng[0]) == E_WAIT
      |-> !$past(st.tx_on) && !$past(st.tx_req)) // [R9]
      else $error("external wait ended during own send");
   AST_AUTO_FALLBACK: assert property (
      $past(clk_src) == CLK_AUTO && !$past(det_present) |-> !st.ext_sel) // [R24]
      else $error("auto mode kept absent outside clock");
   COV_SEND_WAIT: cover property (st.eng[0] == E_WAIT ##[1:1000] chan_done[0]);
   COV_EXT_PULSE: cover property ($fell(trig_oe));
   COV_PS_WAKE: cover property (wake_start);
   COV_AUTO_EXT: cover property (clk_src == CLK_AUTO && st.ext_sel);
endmodule // lss_sequencer_sync

// ==== lss_peer.sv ====
`timescale 1ns/1ps
// peer sequencer that shares the open-drain trigger line
module lss_peer (
   input wire logic slow_clk,
   input wire logic line,
   output logic peer_oe,
   output logic [7:0] low_len
);
   logic [7:0] run_len;
   // length of the latest low period, in slow clock cycles
   always @(posedge slow_clk) begin
      if (!line) begin
         run_len <= run_len + 8'h01;
      end else begin
         if (run_len != 8'h00) low_len <= run_len;
         run_len <= 8'h00;
      end
   end
   // released line floats up through the pull-up
   initial begin
      peer_oe = 1'b0;
      run_len = 8'h00;
      low_len = 8'h00;
   end
   // pull low for n slow cycles; n below two only when a refusal is wanted
   task automatic pull(input int n);
      @(negedge slow_clk);
      peer_oe = 1'b1;
      repeat (n) @(negedge slow_clk);
      peer_oe = 1'b0;
   endtask
endmodule // lss_peer

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
   import lss_pkg::*;
   logic sys_clk, reset_n, reg_wr, slow_clock_input, slow_run;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val, low_len;
   logic trig_out, trig_oe, seq_tick, power_save, wake_start, outside_clock_present, peer_oe;
   logic [2:0] chan_issue, chan_done, pwm_active;
   logic [47:0] chan_instr, time_left, next_wait;
   logic [5:0] chan_mode;
   wire logic trig_line;
   int num_errors = 0;
   int n_tests = 0;
   int ticks = 0;
   int wakes = 0;
   int dones [3] = '{0, 0, 0};
   int base [3] = '{0, 0, 0};
   int t0;
   // open-drain line with pull-up
   assign trig_line = !(trig_oe || peer_oe);
   lss_sequencer_sync #(.DET_CYCLES(400)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .slow_clock_input(slow_clock_input), .trig_in(trig_line), .trig_out(trig_out),
      .trig_oe(trig_oe), .chan_issue(chan_issue), .chan_instr(chan_instr),
      .chan_done(chan_done), .chan_mode(chan_mode), .pwm_active(pwm_active),
      .time_left(time_left), .next_wait(next_wait), .seq_tick(seq_tick),
      .power_save(power_save), .wake_start(wake_start),
      .outside_clock_present(outside_clock_present));
   lss_peer peer (.slow_clk(slow_clock_input), .line(trig_line), .peer_oe(peer_oe),
      .low_len(low_len));
   // system clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // fast outside clock, phase unrelated; stopping it leaves the pin stuck low
   initial begin
      slow_clock_input = 1'b0;
      #3;
      forever #100 slow_clock_input = slow_run & ~slow_clock_input;
   end
   // event counters so one-cycle pulses are never missed
   always @(posedge sys_clk) begin
      if (seq_tick === 1'b1) ticks++;
      if (wake_start === 1'b1) wakes++;
      for (int i = 0; i < 3; i++) if (chan_done[i] === 1'b1) dones[i]++;
   end
   task automatic end_sim();
      if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge sys_clk);
      reg_addr = a;
      cyc(2);
      rd_val = reg_rdata;
   endtask
   task automatic wait_ticks(input int n);
      int t;
      t = ticks + n;
      while (ticks < t) @(negedge sys_clk);
   endtask
   // issue just after a tick so the tick count starts clean
   task automatic issue(input int ch, input logic [15:0] ins);
      @(negedge sys_clk);
      while (seq_tick !== 1'b1) @(negedge sys_clk);
      @(negedge sys_clk);
      chan_instr[16*ch +: 16] = ins;
      chan_issue[ch] = 1'b1;
      t0 = ticks;
      base[ch] = dones[ch];
      @(negedge sys_clk);
      chan_issue[ch] = 1'b0;
   endtask
   task automatic wait_done(input int ch);
      int k;
      for (k = 0; k < 4000 && dones[ch] == base[ch]; k++) @(negedge sys_clk);
      chk("chan_done", 16'(dones[ch] - base[ch]), 16'h0001);
   endtask
   task automatic idle(input int ch);
      chk("chan_done idle", 16'(dones[ch] - base[ch]), 16'h0000);
   endtask
   // red channel varied, green and blue left disabled
   task automatic ps_case(input logic [1:0] m, input logic [15:0] ins, input logic p,
         input logic [15:0] tl, input logic [15:0] nw, input logic exp);
      @(negedge sys_clk);
      chan_mode[1:0] = m;
      chan_instr[15:0] = ins;
      pwm_active[0] = p;
      time_left[15:0] = tl;
      next_wait[15:0] = nw;
      cyc(3);
      chk("power_save", 16'(power_save), 16'(exp));
   endtask
   // watchdog, well beyond the expected run
   initial begin
      #600000;
      num_errors++;
      end_sim();
   end
   // main sequence
   initial begin
      {reg_wr, reg_addr, reg_wdata, chan_issue, chan_instr} = '0;
      {chan_mode, pwm_active, time_left, next_wait} = '0;
      slow_run = 1'b1;
      reset_n = 1'b0;
      cyc(4);
      reset_n = 1'b1;
      rd(REG_SETUP);
      chk("setup reset", 16'(rd_val), 16'h0000);
      wr(REG_SETUP, 8'h02);
      cyc(3);
      chk("power_save off", 16'(power_save), 16'h0000);
      wr(REG_SETUP, 8'h22);
      wr(8'h09, 8'hFF);
      rd(REG_SETUP);
      chk("setup", 16'(rd_val), 16'h0022);
      rd(8'h10);
      chk("unmapped", 16'(rd_val), 16'h0000);
      cyc(200);
      chk("clock present", 16'(outside_clock_present), 16'h0001);
      rd(REG_STATUS);
      chk("status", 16'(rd_val), 16'h0001);
      ps_case(2'h0, 16'h0000, 1'b1, 16'h0000, 16'h0000, 1'b1);
      ps_case(2'h1, 16'h0000, 1'b0, 16'h0000, 16'h0000, 1'b0);
      ps_case(2'h3, 16'h0000, 1'b1, 16'h0000, 16'h0000, 1'b0);
      ps_case(2'h3, 16'h0000, 1'b0, 16'h0000, 16'h0000, 1'b1);
      ps_case(2'h2, 16'h0200, 1'b0, 16'd1639, 16'h0000, 1'b1);
      ps_case(2'h2, 16'h0200, 1'b0, 16'd1638, 16'h0000, 1'b0);
      ps_case(2'h2, 16'h4200, 1'b0, 16'd2622, 16'h0000, 1'b1);
      ps_case(2'h2, 16'h4200, 1'b0, 16'd2621, 16'h0000, 1'b0);
      ps_case(2'h2, 16'h0200, 1'b1, 16'd5000, 16'h0000, 1'b0);
      ps_case(2'h2, 16'h0201, 1'b0, 16'd1639, 16'h0000, 1'b1);
      ps_case(2'h2, 16'h0201, 1'b1, 16'd1639, 16'h0000, 1'b0);
      ps_case(2'h2, 16'h4000, 1'b0, 16'h0000, 16'd1638, 1'b1);
      ps_case(2'h2, 16'h4000, 1'b0, 16'h0000, 16'd1637, 1'b0);
      ps_case(2'h2, 16'h4001, 1'b0, 16'h0000, 16'd5000, 1'b0);
      ps_case(2'h3, 16'h0000, 1'b0, 16'h0000, 16'h0000, 1'b1);
      t0 = wakes;
      pwm_active[0] = 1'b1;
      cyc(4);
      chk("wake_start", 16'(wakes - t0), 16'h0001);
      ps_case(2'h0, 16'h0000, 1'b0, 16'h0000, 16'h0000, 1'b1);
      // triggers run while power save is active
      issue(0, 16'hE004);
      wait_done(0);
      chk("send ticks", 16'(ticks - t0), 16'd16);
      chk("power_save run", 16'(power_save), 16'h0001);
      issue(1, 16'hE080);
      wait_done(1);
      chk("wait ticks", 16'(ticks >= t0 + 16), 16'h0001);
      issue(1, 16'hE080);
      wait_ticks(40);
      idle(1);
      issue(0, 16'hE004);
      wait_done(1);
      wait_done(0);
      issue(2, 16'hF000);
      issue(0, 16'hE040);
      wait_done(0);
      wait_ticks(2);
      chk("pulse length", 16'(low_len), 16'h0003);
      chk("trig_out", 16'(trig_out), 16'h0000);
      wait_ticks(30);
      idle(2);
      peer.pull(1);
      wait_ticks(10);
      idle(2);
      peer.pull(2);
      wait_done(2);
      issue(0, 16'hF000);
      wait_done(0);
      issue(0, 16'hF060 & 16'hF040);
      wait_ticks(30);
      idle(0);
      chk("pulse before wait", 16'(low_len), 16'h0003);
      peer.pull(2);
      wait_done(0);
      // clock source selection with the outside clock stopped
      wr(REG_SETUP, 8'h21);
      slow_run = 1'b0;
      cyc(10);
      t0 = ticks;
      cyc(3200);
      chk("internal ticks", 16'(ticks > t0), 16'h0001);
      wr(REG_SETUP, 8'h20);
      cyc(10);
      t0 = ticks;
      cyc(3200);
      chk("outside ticks", 16'(ticks - t0), 16'h0000);
      wr(REG_SETUP, 8'h22);
      cyc(600);
      chk("clock absent", 16'(outside_clock_present), 16'h0000);
      rd(REG_STATUS);
      chk("status absent", 16'(rd_val), 16'h0000);
      t0 = ticks;
      cyc(3200);
      chk("fallback ticks", 16'(ticks > t0), 16'h0001);
      slow_run = 1'b1;
      cyc(600);
      chk("clock back", 16'(outside_clock_present), 16'h0001);
      end_sim();
   end
endmodule // tb
